// file: logic/dsc_arg_mem.sv
// Search argument store: one write port, two registered read ports.
// Assumes a single clock; contents are undefined until software writes them.
`timescale 1ns/100ps
`default_nettype none
module dsc_arg_mem (
  // Clock
  input  wire logic       clk,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read ports
  input  wire logic [6:0] rd_a_addr,
  output var  logic [7:0] rd_a_data,
  input  wire logic [6:0] rd_b_addr,
  output var  logic [7:0] rd_b_data
);

  logic [7:0] mem [0:dsc_pkg::ARG_DEPTH-1];

  // Out-of-range indexes are dropped on write and read as zero
  always_ff @(posedge clk)
  begin
    if (wr_en && (wr_addr <= dsc_pkg::ARG_LAST))
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_data <= (rd_a_addr <= dsc_pkg::ARG_LAST) ? mem[rd_a_addr] : 8'h00;
    rd_b_data <= (rd_b_addr <= dsc_pkg::ARG_LAST) ? mem[rd_b_addr] : 8'h00;
  end

endmodule : dsc_arg_mem
`default_nettype wire

// file: logic/dsc_pkg.sv
// Constants, register map and state types shared by the disk scan-compare block.
// Assumes a 10 MHz MCLK and an AHB-Lite master with single word transfers.
package dsc_pkg;

  // Clock rate and the longest full-cylinder scan
  localparam int unsigned CLK_KHZ      = 10000;
  localparam int unsigned SCAN_MAX_MS  = 400;
  localparam int unsigned SCAN_MAX_CYC = SCAN_MAX_MS * CLK_KHZ;

  // Compare-mode codes, as the units digit of the operand field
  localparam logic [3:0] MODE_LOW_EQ  = 4'h7;
  localparam logic [3:0] MODE_EQUAL   = 4'h8;
  localparam logic [3:0] MODE_HIGH_EQ = 4'h9;

  // Search argument store: 100 positions, the last one never compared
  localparam int unsigned ARG_DEPTH = 100;
  localparam logic [6:0]  ARG_LAST  = 7'h63;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_START  = 12'h004;
  localparam logic [11:0] OFS_COUNT  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_ISTAT  = 12'h010;
  localparam logic [11:0] OFS_IMASK  = 12'h014;
  localparam logic [11:0] OFS_CUR    = 12'h018;
  localparam logic [11:0] OFS_ARG    = 12'h100;
  localparam logic [11:0] OFS_ARG_END = 12'h290;

  // Field positions
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned ENTRY_GM_BIT   = 7;
  localparam int unsigned ENTRY_SKIP_BIT = 6;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_TIME_BIT   = 1;

  // Reset values of software fields
  localparam logic [3:0]  RST_MODE  = 4'h8;
  localparam logic [19:0] RST_START = 20'h00000;
  localparam logic [9:0]  RST_COUNT = 10'h000;

  typedef enum logic [1:0] {
    DSC_IDLE = 2'b00,
    DSC_SCAN = 2'b01,
    DSC_EVAL = 2'b11
  } dsc_fsm_t;

  typedef enum logic [1:0] {
    REL_EQ   = 2'b00,
    REL_HIGH = 2'b01,
    REL_LOW  = 2'b10
  } dsc_rel_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_W1   = 2'b01,
    BUS_W2   = 2'b11,
    BUS_DONE = 2'b10
  } dsc_bus_t;

  typedef struct packed {
    dsc_bus_t    bphase;
    logic [11:0] b_addr;
    logic        b_write;
    logic        hready;
    logic [31:0] hrdata;
    logic [3:0]  mode;
    logic [19:0] start_addr;
    logic [9:0]  count;
    logic [19:0] cur_addr;
    logic        ind_high;
    logic        ind_low;
    logic        ind_equal;
    logic        stop_match;
    logic        stop_cyl;
    logic        stop_count;
    logic        stop_time;
    logic        bad_mode;
    logic [1:0]  istat;
    logic [1:0]  imask;
    logic        irq;
    dsc_fsm_t    fsm;
    dsc_rel_t    rel;
    logic [6:0]  idx;
    logic        arg_end;
    logic        cyl_seen;
    logic [31:0] timer;
    logic [2:0]  strb_s;
    logic [2:0]  send_s;
    logic [1:0]  cyl_s;
    logic [5:0]  char_s1;
    logic [5:0]  char_s2;
    logic        dsk_read;
  } dsc_state_t;

  localparam dsc_state_t DSC_RESET = '{
    bphase: BUS_IDLE, b_addr: 12'h000, b_write: 1'b0, hready: 1'b1, hrdata: 32'h00000000,
    mode: RST_MODE, start_addr: RST_START, count: RST_COUNT, cur_addr: 20'h00000,
    ind_high: 1'b0, ind_low: 1'b0, ind_equal: 1'b0, stop_match: 1'b0, stop_cyl: 1'b0,
    stop_count: 1'b0, stop_time: 1'b0, bad_mode: 1'b0, istat: 2'h0, imask: 2'h0,
    irq: 1'b0, fsm: DSC_IDLE, rel: REL_EQ, idx: 7'h00, arg_end: 1'b0, cyl_seen: 1'b0,
    timer: 32'h00000000, strb_s: 3'h0, send_s: 3'h0, cyl_s: 2'h0, char_s1: 6'h00,
    char_s2: 6'h00, dsk_read: 1'b0};

endpackage : dsc_pkg

// file: logic/dsc_scan.sv
// Disk scan-compare engine with its AHB-Lite register slave.
// Assumes the drive streams sector characters on slow strobes from another clock domain.
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module dsc_scan #(
  parameter int unsigned SCAN_LIMIT_CYC = dsc_pkg::SCAN_MAX_CYC
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output var  logic        HREADYOUT,
  output var  logic [31:0] HRDATA,
  output var  logic        HRESP,
  // Interrupt
  output var  logic        IRQ,
  // Compare indicators
  output var  logic        CMP_HIGH,
  output var  logic        CMP_LOW,
  output var  logic        CMP_EQUAL,
  // Disk drive
  input  wire logic [5:0]  DSK_CHAR,
  input  wire logic        DSK_STRB,
  input  wire logic        DSK_SECT_END,
  input  wire logic        DSK_CYL_END,
  output var  logic        DSK_READ,
  output var  logic [19:0] DSK_SECTOR
);

  dsc_pkg::dsc_state_t st_reg;
  dsc_pkg::dsc_state_t st_next;
  logic [7:0]          arg_bus;
  logic [7:0]          arg_scan;
  logic                mem_we;
  logic [6:0]          bus_idx;

  // Word index of a store address; the store starts at its own base
  function automatic logic [6:0] arg_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - dsc_pkg::OFS_ARG;
    return d[8:2];
  endfunction : arg_index

  function automatic logic is_arg(input logic [11:0] a);
    return (a >= dsc_pkg::OFS_ARG) && (a < dsc_pkg::OFS_ARG_END);
  endfunction : is_arg

  function automatic logic mode_ok(input logic [3:0] m);
    return (m == dsc_pkg::MODE_LOW_EQ) || (m == dsc_pkg::MODE_EQUAL) ||
           (m == dsc_pkg::MODE_HIGH_EQ);
  endfunction : mode_ok

  // Store writes land at the end of the first wait cycle
  assign bus_idx = arg_index(st_reg.b_addr);
  assign mem_we  = (st_reg.bphase == dsc_pkg::BUS_W1) && st_reg.b_write && is_arg(st_reg.b_addr);

  dsc_arg_mem u_mem (
    .clk       (MCLK),
    .wr_en     (mem_we),
    .wr_addr   (bus_idx),
    .wr_data   (HWDATA[7:0]),
    .rd_a_addr (bus_idx),
    .rd_a_data (arg_bus),
    .rd_b_addr (st_reg.idx),
    .rd_b_data (arg_scan)
  );

  // Next-state logic for bus, registers, synchronisers and scan engine
  always_comb
  begin
    logic       take;
    logic       wr_ok;
    logic       strb_edge;
    logic       send_edge;
    logic       start_go;
    logic       hit;
    logic [9:0] cnt_dec;
    logic [1:0] w1c;
    logic [1:0] ev;
    take      = 1'b0;
    wr_ok     = 1'b0;
    strb_edge = 1'b0;
    send_edge = 1'b0;
    start_go  = 1'b0;
    hit       = 1'b0;
    cnt_dec   = 10'h000;
    w1c       = 2'h0;
    ev        = 2'h0;
    st_next   = st_reg;

    // At least two flops on every drive pin; edges look only at the second and third stage
    st_next.strb_s  = {st_reg.strb_s[1:0], DSK_STRB};
    st_next.send_s  = {st_reg.send_s[1:0], DSK_SECT_END};
    st_next.cyl_s   = {st_reg.cyl_s[0], DSK_CYL_END};
    st_next.char_s1 = DSK_CHAR;
    st_next.char_s2 = st_reg.char_s1;
    strb_edge = st_reg.strb_s[1] & ~st_reg.strb_s[2];
    send_edge = st_reg.send_s[1] & ~st_reg.send_s[2];

    // Bus phases: two wait states give registered read data and settled writes
    take = HSEL && HTRANS[1] && HREADY &&
           ((st_reg.bphase == dsc_pkg::BUS_IDLE) || (st_reg.bphase == dsc_pkg::BUS_DONE));
    case (st_reg.bphase)
      dsc_pkg::BUS_IDLE, dsc_pkg::BUS_DONE:
      begin
        st_next.bphase = take ? dsc_pkg::BUS_W1 : dsc_pkg::BUS_IDLE;
        if (take)
        begin
          st_next.b_addr  = HADDR[11:0];
          st_next.b_write = HWRITE;
        end
      end
      dsc_pkg::BUS_W1: st_next.bphase = dsc_pkg::BUS_W2;
      dsc_pkg::BUS_W2: st_next.bphase = dsc_pkg::BUS_DONE;
      default:         st_next.bphase = dsc_pkg::BUS_IDLE;
    endcase
    st_next.hready = (st_next.bphase == dsc_pkg::BUS_IDLE) ||
                     (st_next.bphase == dsc_pkg::BUS_DONE);

    // Register writes; setup fields are frozen while a scan runs
    wr_ok = (st_reg.bphase == dsc_pkg::BUS_W1) && st_reg.b_write;
    if (wr_ok)
    begin
      case (st_reg.b_addr)
        dsc_pkg::OFS_CTRL:
        begin
          if (st_reg.fsm == dsc_pkg::DSC_IDLE)
          begin
            st_next.mode = HWDATA[3:0];
            start_go     = HWDATA[dsc_pkg::CTRL_START_BIT];
          end
        end
        dsc_pkg::OFS_START:
          if (st_reg.fsm == dsc_pkg::DSC_IDLE) st_next.start_addr = HWDATA[19:0];
        dsc_pkg::OFS_COUNT:
          if (st_reg.fsm == dsc_pkg::DSC_IDLE) st_next.count = HWDATA[9:0];
        dsc_pkg::OFS_ISTAT: w1c = HWDATA[1:0];
        dsc_pkg::OFS_IMASK: st_next.imask = HWDATA[1:0];
        default: ;
      endcase
    end

    // Read data captured at the end of the second wait cycle
    if (st_reg.bphase == dsc_pkg::BUS_W2)
    begin
      st_next.hrdata = 32'h00000000;
      if (!st_reg.b_write)
      begin
        case (st_reg.b_addr)
          dsc_pkg::OFS_CTRL:   st_next.hrdata = {28'h0000000, st_reg.mode};
          dsc_pkg::OFS_START:  st_next.hrdata = {12'h000, st_reg.start_addr};
          dsc_pkg::OFS_COUNT:  st_next.hrdata = {22'h000000, st_reg.count};
          dsc_pkg::OFS_STATUS: st_next.hrdata = {23'h000000, st_reg.bad_mode,
                                 st_reg.stop_time, st_reg.stop_count, st_reg.stop_cyl,
                                 st_reg.stop_match, st_reg.ind_equal, st_reg.ind_low,
                                 st_reg.ind_high, (st_reg.fsm != dsc_pkg::DSC_IDLE)};
          dsc_pkg::OFS_ISTAT:  st_next.hrdata = {30'h00000000, st_reg.istat};
          dsc_pkg::OFS_IMASK:  st_next.hrdata = {30'h00000000, st_reg.imask};
          dsc_pkg::OFS_CUR:    st_next.hrdata = {12'h000, st_reg.cur_addr};
          default:
            if (is_arg(st_reg.b_addr)) st_next.hrdata = {24'h000000, arg_bus};
        endcase
      end
    end

    // Scan engine
    cnt_dec = st_reg.count - 10'h001;
    case (st_reg.fsm)
      dsc_pkg::DSC_IDLE:
      begin
        if (start_go)
        begin
          st_next.ind_high   = 1'b0;
          st_next.ind_low    = 1'b0;
          st_next.ind_equal  = 1'b0;
          st_next.stop_match = 1'b0;
          st_next.stop_cyl   = 1'b0;
          st_next.stop_count = 1'b0;
          st_next.stop_time  = 1'b0;
          st_next.bad_mode   = 1'b0;
          st_next.cur_addr   = st_reg.start_addr;
          st_next.timer      = 32'h00000000;
          if (!mode_ok(HWDATA[3:0]))
          begin
            st_next.bad_mode = 1'b1;
            ev[dsc_pkg::IRQ_DONE_BIT] = 1'b1;
          end
          else if (st_reg.count == 10'h000)
          begin
            st_next.stop_count = 1'b1;
            ev[dsc_pkg::IRQ_DONE_BIT] = 1'b1;
          end
          else
          begin
            st_next.fsm     = dsc_pkg::DSC_SCAN;
            st_next.rel     = dsc_pkg::REL_EQ;
            st_next.idx     = 7'h00;
            st_next.arg_end = 1'b0;
          end
        end
      end
      dsc_pkg::DSC_SCAN:
      begin
        st_next.timer = st_reg.timer + 32'h00000001;
        if (st_reg.timer >= 32'(SCAN_LIMIT_CYC) - 32'h00000001)
        begin
          st_next.stop_time = 1'b1;
          st_next.fsm       = dsc_pkg::DSC_IDLE;
          ev[dsc_pkg::IRQ_TIME_BIT] = 1'b1;
        end
        else if (send_edge)
        begin
          st_next.cyl_seen = st_reg.cyl_s[1];
          st_next.fsm      = dsc_pkg::DSC_EVAL;
        end
        else if (strb_edge && !st_reg.arg_end)
        begin
          // High-order first; first differing unskipped position decides
          if (arg_scan[dsc_pkg::ENTRY_GM_BIT] || (st_reg.idx == dsc_pkg::ARG_LAST))
          begin
            st_next.arg_end = 1'b1;
          end
          else
          begin
            if (!arg_scan[dsc_pkg::ENTRY_SKIP_BIT] && (st_reg.rel == dsc_pkg::REL_EQ))
            begin
              if (arg_scan[5:0] > st_reg.char_s2) st_next.rel = dsc_pkg::REL_HIGH;
              else if (arg_scan[5:0] < st_reg.char_s2) st_next.rel = dsc_pkg::REL_LOW;
            end
            st_next.idx = st_reg.idx + 7'h01;
          end
        end
      end
      dsc_pkg::DSC_EVAL:
      begin
        // Indicators follow every record, so a stop made in DSC_EVAL always shows its relation
        st_next.ind_high  = (st_reg.rel == dsc_pkg::REL_HIGH);
        st_next.ind_low   = (st_reg.rel == dsc_pkg::REL_LOW);
        st_next.ind_equal = (st_reg.rel == dsc_pkg::REL_EQ);
        case (st_reg.mode)
          dsc_pkg::MODE_LOW_EQ:  hit = (st_reg.rel != dsc_pkg::REL_HIGH);
          dsc_pkg::MODE_HIGH_EQ: hit = (st_reg.rel != dsc_pkg::REL_LOW);
          default:               hit = (st_reg.rel == dsc_pkg::REL_EQ);
        endcase
        if (!hit)
        begin
          st_next.count    = cnt_dec;
          st_next.cur_addr = st_reg.cur_addr + 20'h00001;
        end
        st_next.stop_match = hit;
        st_next.stop_cyl   = st_reg.cyl_seen;
        st_next.stop_count = !hit && (cnt_dec == 10'h000);
        if (hit || st_reg.cyl_seen || (cnt_dec == 10'h000))
        begin
          st_next.fsm = dsc_pkg::DSC_IDLE;
          ev[dsc_pkg::IRQ_DONE_BIT] = 1'b1;
        end
        else
        begin
          st_next.fsm     = dsc_pkg::DSC_SCAN;
          st_next.rel     = dsc_pkg::REL_EQ;
          st_next.idx     = 7'h00;
          st_next.arg_end = 1'b0;
        end
      end
      default: st_next.fsm = dsc_pkg::DSC_IDLE;
    endcase

    // New events win over a clear in the same cycle
    st_next.istat    = (st_reg.istat & ~w1c) | ev;
    st_next.irq      = |(st_next.istat & st_next.imask);
    st_next.dsk_read = (st_next.fsm != dsc_pkg::DSC_IDLE);
  end

  // Single state register, synchronous reset
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      st_reg <= dsc_pkg::DSC_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register, except HRESP tied low
  assign HREADYOUT  = st_reg.hready;
  assign HRDATA     = st_reg.hrdata;
  assign HRESP      = 1'b0;
  assign IRQ        = st_reg.irq;
  assign CMP_HIGH   = st_reg.ind_high;
  assign CMP_LOW    = st_reg.ind_low;
  assign CMP_EQUAL  = st_reg.ind_equal;
  assign DSK_READ   = st_reg.dsk_read;
  assign DSK_SECTOR = st_reg.cur_addr;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  chk_low_eq_stop: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) &&
    (st_reg.mode == dsc_pkg::MODE_LOW_EQ) && (st_reg.rel == dsc_pkg::REL_LOW)
    |=> (st_reg.fsm == dsc_pkg::DSC_IDLE) && st_reg.stop_match && CMP_LOW)
    else $error("low-or-equal match did not stop the scan");
  chk_equal_only: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) &&
    (st_reg.mode == dsc_pkg::MODE_EQUAL) && (st_reg.rel != dsc_pkg::REL_EQ) &&
    !st_reg.cyl_seen && (st_reg.count > 10'h001) |=> (st_reg.fsm == dsc_pkg::DSC_SCAN))
    else $error("equal mode stopped without an equal record");
  chk_high_eq_stop: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) &&
    (st_reg.mode == dsc_pkg::MODE_HIGH_EQ) && (st_reg.rel == dsc_pkg::REL_HIGH)
    |=> (st_reg.fsm == dsc_pkg::DSC_IDLE) && st_reg.stop_match ##1 IRQ || !st_reg.imask[0])
    else $error("high-or-equal match did not stop the scan");
  chk_cyl_end_stop: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) && st_reg.cyl_seen
    |=> (st_reg.fsm == dsc_pkg::DSC_IDLE) && st_reg.stop_cyl && st_reg.istat[0])
    else $error("end of cylinder did not end the scan");
  chk_count_step: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) && !st_next.stop_match
    |=> (st_reg.count == $past(st_reg.count) - 10'h001) &&
        (DSK_SECTOR == $past(st_reg.cur_addr) + 20'h00001))
    else $error("unmatched sector did not step count and address");
  chk_one_indicator: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL)
    |=> $onehot({CMP_HIGH, CMP_LOW, CMP_EQUAL}))
    else $error("not exactly one compare indicator set");
  chk_equal_shown: assert property ((st_reg.fsm == dsc_pkg::DSC_EVAL) &&
    (st_reg.rel == dsc_pkg::REL_EQ) |=> CMP_EQUAL && !CMP_HIGH && !CMP_LOW)
    else $error("equal relation not shown on indicator");
  chk_start_sector: assert property ((st_reg.fsm == dsc_pkg::DSC_IDLE) &&
    (st_next.fsm == dsc_pkg::DSC_SCAN) |=> DSK_READ && (DSK_SECTOR == $past(st_reg.start_addr)))
    else $error("scan did not begin at the start sector");
  chk_arg_end_mark: assert property ((st_reg.fsm == dsc_pkg::DSC_SCAN) &&
    (st_reg.strb_s[1] & ~st_reg.strb_s[2]) && !(st_reg.send_s[1] & ~st_reg.send_s[2]) &&
    (st_reg.timer < 32'(SCAN_LIMIT_CYC) - 32'h00000001) && arg_scan[dsc_pkg::ENTRY_GM_BIT]
    |=> st_reg.arg_end && $stable(st_reg.rel))
    else $error("group mark did not end the argument");
  chk_skip_ignored: assert property ((st_reg.fsm == dsc_pkg::DSC_SCAN) &&
    (st_reg.strb_s[1] & ~st_reg.strb_s[2]) && arg_scan[dsc_pkg::ENTRY_SKIP_BIT]
    |=> $stable(st_reg.rel))
    else $error("skip-coded position changed the relation");
  chk_scan_bounded: assert property ((st_reg.fsm != dsc_pkg::DSC_IDLE)
    |-> (st_reg.timer < 32'(SCAN_LIMIT_CYC)))
    else $error("scan ran past its time bound");
  chk_read_active: assert property ((st_reg.fsm == dsc_pkg::DSC_SCAN) |-> DSK_READ)
    else $error("drive not reading during scan");

endmodule : dsc_scan
`default_nettype wire

// file: verif/dsc_drive_model.sv
// Disk drive model: streams sector records while the engine reads.
// Assumes the engine clock; strobes are slow enough for its sync.
`timescale 1ns/100ps
`default_nettype none
module dsc_drive_model #(
  parameter logic [19:0] CYL_LAST = 20'h0000c
) (
  // Clock and stall
  input  wire logic        clk,
  input  wire logic        stall,
  // Engine side
  input  wire logic        rd,
  input  wire logic [19:0] sector,
  output var  logic [5:0]  chr,
  output var  logic        strb,
  output var  logic        sect_end,
  output var  logic        cyl_end
);
  logic [5:0] rec [5];
  int         i;
  // First char is the sector number, so a scan can be aimed at one
  initial
  begin
    chr      = 6'h00;
    strb     = 1'b0;
    sect_end = 1'b0;
    cyl_end  = 1'b0;
    forever
    begin
      @(posedge clk);
      if (rd && !stall)
      begin
        rec = '{sector[5:0], 6'h2a, 6'h10, 6'h01, 6'h3f};
        cyl_end <= (sector == CYL_LAST);
        for (i = 0; i < 5; i++)
        begin
          chr <= rec[i];
          repeat (2) @(posedge clk);
          strb <= 1'b1;
          repeat (4) @(posedge clk);
          strb <= 1'b0;
          repeat (2) @(posedge clk);
        end
        chr <= ~rec[4]; // Released line never shows a stale value
        sect_end <= 1'b1;
        repeat (4) @(posedge clk);
        sect_end <= 1'b0;
        cyl_end  <= 1'b0;
        repeat (10) @(posedge clk); // Room for the engine to decide
      end
    end
  end
endmodule : dsc_drive_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the disk scan-compare block.
// Assumes the drive model beside it and a 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned LIM = 2000;
  typedef struct packed {
    logic [3:0] m; logic [19:0] s; logic [9:0] c; logic [5:0] a;
    logic [8:0] st; logic [19:0] cur; logic [9:0] cnt; logic pos;
  } dsc_row_t;
  // Bus and disk wires
  logic        mclk   = 1'b0;
  logic        nrst   = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        stall  = 1'b0;
  logic [31:0] r;
  wire  logic  hrdy, hresp, irq, c_h, c_l, c_e, rd, strb, s_end, c_end;
  wire  logic [31:0] hrdata;
  wire  logic [5:0]  chr;
  wire  logic [19:0] sect;
  int          n_errors = 0;
  int          n_checks = 0;
  int          i;
  dsc_row_t    rows [6] = '{
    '{4'h7, 20'h2, 10'ha, 6'h05, 9'h018, 20'h5, 10'h7, 1'b1},
    '{4'h8, 20'h2, 10'ha, 6'h05, 9'h018, 20'h5, 10'h7, 1'b1},
    '{4'h9, 20'h2, 10'ha, 6'h05, 9'h012, 20'h2, 10'ha, 1'b1},
    '{4'h7, 20'h7, 10'ha, 6'h05, 9'h014, 20'h7, 10'ha, 1'b1},
    '{4'h8, 20'h7, 10'h3, 6'h05, 9'h044, 20'ha, 10'h0, 1'b1},
    '{4'h9, 20'h7, 10'ha, 6'h05, 9'h024, 20'h0, 10'h0, 1'b0}};
  // Units under test
  dsc_scan #(.SCAN_LIMIT_CYC(LIM)) dsc_scan_inst (.MCLK(mclk), .NRST(nrst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp),
    .IRQ(irq), .CMP_HIGH(c_h), .CMP_LOW(c_l), .CMP_EQUAL(c_e), .DSK_CHAR(chr),
    .DSK_STRB(strb), .DSK_SECT_END(s_end), .DSK_CYL_END(c_end), .DSK_READ(rd),
    .DSK_SECTOR(sect));
  dsc_drive_model dsc_drive_model_inst (.clk(mclk), .stall(stall), .rd(rd),
    .sector(sect), .chr(chr), .strb(strb), .sect_end(s_end), .cyl_end(c_end));
  // Clock
  always #50 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One single-word transfer; read data lands in r
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, a};
    @(posedge mclk);
    while (hrdy !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hrdy !== 1'b1) @(posedge mclk);
    r = hrdata;
  endtask : bus
  task automatic start(input logic [3:0] m, input logic [19:0] s, input logic [9:0] c);
    bus(1'b1, dsc_pkg::OFS_START, {12'h0, s});
    bus(1'b1, dsc_pkg::OFS_COUNT, {22'h0, c});
    bus(1'b1, dsc_pkg::OFS_CTRL, {23'h0, 1'b1, 4'h0, m});
  endtask : start
  // Polling bounded; the watchdog covers a stuck bus
  task automatic wait_idle;
    int k;
    k = 0;
    bus(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
    while (r[0] !== 1'b0 && k < LIM)
    begin
      bus(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
      k++;
    end
    chk("status", r & 32'h1ff, r & 32'h1fe);
  endtask : wait_idle
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Watchdog
  initial
  begin
    #(100 * 40000);
    n_errors++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    bus(1'b0, dsc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", r, {28'h0, dsc_pkg::RST_MODE});
    bus(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
    chk("status", r, 32'h0);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", r, 32'h0);
    chk("resp", {31'h0, hresp}, 32'h0);
    $display("reset test done");
    // Skip, compared char, end mark, then a char past the mark
    bus(1'b1, dsc_pkg::OFS_ARG + 12'h004, 32'h40);
    bus(1'b1, dsc_pkg::OFS_ARG + 12'h008, 32'h10);
    bus(1'b1, dsc_pkg::OFS_ARG + 12'h00c, 32'h80);
    bus(1'b1, dsc_pkg::OFS_ARG + 12'h010, 32'h00);
    bus(1'b1, dsc_pkg::OFS_IMASK, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      bus(1'b1, dsc_pkg::OFS_ARG, {26'h0, rows[i].a});
      start(rows[i].m, rows[i].s, rows[i].c);
      chk("sector", {12'h0, sect}, {12'h0, rows[i].s});
      chk("read", {31'h0, rd}, 32'h1);
      wait_idle();
      chk("result", r & 32'h1ff, {23'h0, rows[i].st});
      chk("ind", {29'h0, c_e, c_l, c_h}, {29'h0, rows[i].st[3:1]});
      if (rows[i].pos)
      begin
        bus(1'b0, dsc_pkg::OFS_CUR, 32'h0);
        chk("cur", r, {12'h0, rows[i].cur});
        bus(1'b0, dsc_pkg::OFS_COUNT, 32'h0);
        chk("count", r, {22'h0, rows[i].cnt});
      end
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, dsc_pkg::OFS_ISTAT, 32'h3);
      chk("irq clr", {31'h0, irq}, 32'h0);
      $display("row %0d done", i);
    end
    // Bad mode code, then the done flag masked
    start(4'h3, 20'h2, 10'h5);
    wait_idle();
    chk("bad mode", r & 32'h1ff, 32'h100);
    bus(1'b1, dsc_pkg::OFS_IMASK, 32'h0);
    chk("irq mask", {31'h0, irq}, 32'h0);
    bus(1'b1, dsc_pkg::OFS_ISTAT, 32'h3);
    start(4'h7, 20'h2, 10'h0);
    wait_idle();
    chk("count zero", r & 32'h1ff, 32'h040);
    $display("mode and count tests done");
    // Stalled drive runs into the scan time bound
    bus(1'b1, dsc_pkg::OFS_IMASK, 32'h2);
    stall <= 1'b1;
    start(4'h8, 20'h2, 10'h5);
    wait_idle();
    stall <= 1'b0;
    chk("timeout", r & 32'h1ff, 32'h080);
    bus(1'b0, dsc_pkg::OFS_ISTAT, 32'h0);
    chk("istat", r & 32'h2, 32'h2);
    chk("irq to", {31'h0, irq}, 32'h1);
    $display("timeout test done");
    // Reset in mid-scan, inside the second record of an unmatched run
    start(4'h8, 20'h2, 10'h5);
    repeat (80) @(posedge mclk);
    chk("mid sector", {12'h0, sect}, 32'h3);
    chk("mid ind", {29'h0, c_e, c_l, c_h}, 32'h1);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("rst read", {31'h0, rd}, 32'h0);
    chk("rst sector", {12'h0, sect}, 32'h0);
    chk("rst ind", {28'h0, irq, c_e, c_l, c_h}, 32'h0);
    chk("rst ready", {31'h0, hrdy}, 32'h1);
    bus(1'b0, dsc_pkg::OFS_COUNT, 32'h0);
    chk("rst count", r, 32'h0);
    $display("mid-run reset test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
